//--- common/qdsc_pkg.sv
// constants and types shared by the quad converter serial command decoder
// assumes one clock domain (aclk) and an AXI4-Lite register bus of 32-bit words
// Notes on behaviour
// - a command word is 16 bits, msb first: load 2, channel 2, payload 12
// - after frame sync falls, 16 falling serial clock edges shift; later edges ignored
// - frame sync rising before the sixteenth edge discards the partial word
// - reset clears every bus-visible register except the enable bit, which comes up set, so every channel sits at zero scale
// - load code 01 copies the picked input register into its converter register
// - load code 10 writes payload into both registers of the picked channel
// - load code 11: channel code 00/01/10 does the same for all four channels
// - all four control bits set means a power-down command, no data loads
// - payload bit 11 set applies the power-down setting to all channels
// - payload bit 11 clear: bits 10 and 9 pick the one affected channel
// - payload bits 8 and 7 pick termination: hi-z, 1k, 100k, hi-z
// - payload bits 6 down to 0 of a power-down command are ignored
// - 1k termination works for all channels as well as for one
// - a single-channel 100k command leaves the other three channels untouched
package qdsc_pkg;
    localparam int unsigned NCHAN       = 4;
    localparam int unsigned DATA_W      = 12;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned CNT_W       = 5;
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned SYNC_STAGES = 3;

    // shift count at which a word is complete
    localparam logic [CNT_W-1:0] LAST_BIT_CNT = 5'h0f;

    // register map, byte addresses
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LAST   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PD     = 8'h0c;
    localparam logic [3:0]        BANK_INREG = 4'h1;
    localparam logic [3:0]        BANK_CONV  = 4'h2;

    // field positions
    localparam int unsigned CTRL_EN_BIT    = 0;
    localparam int unsigned ST_ACTIVE_BIT  = 0;
    localparam int unsigned ST_CNT_LSB     = 1;
    localparam int unsigned ST_DONE_BIT    = 8;
    localparam int unsigned ST_ABORT_BIT   = 9;
    localparam int unsigned PD_TERM_LSB    = 4;
    localparam int unsigned ALL_FLAG_BIT   = 11;
    localparam int unsigned PD_PICK_LSB    = 9;
    localparam int unsigned PD_TERM_BIT_LO = 7;

    // values after reset
    localparam logic               CTRL_EN_RST = 1'b1;
    localparam logic [DATA_W-1:0]  ZERO_SCALE  = 12'h000;
    localparam logic [1:0]         TERM_RST    = 2'h0;
    localparam logic [WORD_W-1:0]  WORD_RST    = 16'h0000;

    // load-control codes
    localparam logic [1:0] LD_STORE  = 2'h0;
    localparam logic [1:0] LD_UPDATE = 2'h1;
    localparam logic [1:0] LD_BOTH   = 2'h2;
    localparam logic [1:0] LD_BCAST  = 2'h3;
    // channel codes under broadcast
    localparam logic [1:0] BC_STORE  = 2'h0;
    localparam logic [1:0] BC_UPDATE = 2'h1;
    localparam logic [1:0] BC_BOTH   = 2'h2;
    localparam logic [1:0] BC_PDOWN  = 2'h3;
    // termination codes
    localparam logic [1:0] TERM_HIZ  = 2'h0;
    localparam logic [1:0] TERM_1K   = 2'h1;
    localparam logic [1:0] TERM_100K = 2'h2;
    localparam logic [1:0] TERM_HIZ2 = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_HOLD  = 2'b10
    } qdsc_state_t;
endpackage : qdsc_pkg

//--- logic/qdsc_pin_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes pins change slowly compared with aclk; a level moves once stages 1 and 2 agree
`timescale 1ns/1ps
`default_nettype none
module qdsc_pin_sync
    import qdsc_pkg::*;
#(
    parameter int unsigned     W       = 3,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // raw pins and filtered levels
    input  wire logic [W-1:0]  pins_in,
    output logic      [W-1:0]  pins_level
);
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic [SYNC_STAGES-1:0] stage_q;
        logic                   level_q;
        // stage 0 feeds stage 1 only
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                stage_q <= {SYNC_STAGES{RST_VAL[i]}};
                level_q <= RST_VAL[i];
            end else begin
                stage_q <= {stage_q[SYNC_STAGES-2:0], pins_in[i]};
                if (stage_q[1] == stage_q[2]) begin
                    level_q <= stage_q[2];
                end
            end
        end
        assign pins_level[i] = level_q;
    end
endmodule : qdsc_pin_sync
`default_nettype wire

//--- logic/qdsc_decoder.sv
// serial command decoder for a four-channel converter, with AXI4-Lite status/control
// assumes link pins are asynchronous to aclk and sclk is well below aclk/8
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module qdsc_decoder
    import qdsc_pkg::*;
(
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0]             s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // serial link pins
    input  wire logic                          link_sclk,
    input  wire logic                          link_din,
    input  wire logic                          link_frame_n,
    // per-channel results
    output logic [NCHAN-1:0][DATA_W-1:0]       conv_value,
    output logic [NCHAN-1:0]                   power_down_state,
    output logic [NCHAN-1:0][1:0]              out_term
);
    // pin filtering
    logic [2:0] pin_lvl;
    logic       sclk_l;
    logic       din_l;
    logic       frame_n_l;

    qdsc_pin_sync #(
        .W       (3),
        .RST_VAL (3'h5)
    ) u_sync (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pins_in    ({link_frame_n, link_din, link_sclk}),
        .pins_level (pin_lvl)
    );

    assign sclk_l    = pin_lvl[0];
    assign din_l     = pin_lvl[1];
    assign frame_n_l = pin_lvl[2];

    // edge detection on the filtered levels
    logic sclk_prev_q;
    logic frame_prev_q;
    logic sclk_fall;
    logic frame_fall;
    logic frame_rise;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_prev_q  <= 1'b1;
            frame_prev_q <= 1'b1;
        end else begin
            sclk_prev_q  <= sclk_l;
            frame_prev_q <= frame_n_l;
        end
    end

    assign sclk_fall  = sclk_prev_q & ~sclk_l;
    assign frame_fall = frame_prev_q & ~frame_n_l;
    assign frame_rise = ~frame_prev_q & frame_n_l;

    // software control and status
    logic ctrl_en_q;
    logic done_q;
    logic abort_q;

    // frame state machine
    qdsc_state_t           state_q;
    logic [CNT_W-1:0]      cnt_q;
    logic [WORD_W-2:0]     shift_q;
    logic [WORD_W-1:0]     word_q;
    logic                  exec_q;
    logic                  abort_evt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q     <= ST_IDLE;
            cnt_q       <= '0;
            shift_q     <= '0;
            exec_q      <= 1'b0;
            abort_evt_q <= 1'b0;
        end else begin
            exec_q      <= 1'b0;
            abort_evt_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // a frame already low when enabled is skipped entirely
                    if (frame_fall && ctrl_en_q) begin
                        state_q <= ST_SHIFT;
                        cnt_q   <= '0;
                    end
                end
                ST_SHIFT: begin
                    if (frame_rise) begin
                        state_q     <= ST_IDLE;
                        abort_evt_q <= 1'b1;
                    end else if (sclk_fall) begin
                        shift_q <= {shift_q[WORD_W-3:0], din_l};
                        cnt_q   <= cnt_q + 5'h01;
                        if (cnt_q == LAST_BIT_CNT) begin
                            state_q <= ST_HOLD;
                            exec_q  <= 1'b1;
                        end
                    end
                end
                ST_HOLD: begin
                    // further edges ignored until frame sync rises
                    if (frame_rise) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // last completed word, msb first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_q <= WORD_RST;
        end else if (state_q == ST_SHIFT && !frame_rise && sclk_fall
                     && cnt_q == LAST_BIT_CNT) begin
            word_q <= {shift_q, din_l};
        end
    end

    // command decode
    logic [1:0]         load_ctrl;
    logic [1:0]         chan_pick;
    logic [DATA_W-1:0]  payload_bits;
    logic               load_ctrl_hi;
    logic               load_ctrl_lo;
    logic               chan_pick_hi;
    logic               chan_pick_lo;
    logic               pd_cmd;
    logic               all_channels_flag;
    logic [1:0]         pd_chan_pick;
    logic [1:0]         pd_term;

    assign load_ctrl_hi      = word_q[15];
    assign load_ctrl_lo      = word_q[14];
    assign chan_pick_hi      = word_q[13];
    assign chan_pick_lo      = word_q[12];
    assign load_ctrl         = {load_ctrl_hi, load_ctrl_lo};
    assign chan_pick         = {chan_pick_hi, chan_pick_lo};
    assign payload_bits      = word_q[DATA_W-1:0];
    assign pd_cmd            = (load_ctrl == LD_BCAST) && (chan_pick == BC_PDOWN);
    assign all_channels_flag = payload_bits[ALL_FLAG_BIT];
    assign pd_chan_pick      = payload_bits[PD_PICK_LSB +: 2];
    // bits 6..0 never looked at
    assign pd_term           = payload_bits[PD_TERM_BIT_LO +: 2];

    logic [NCHAN-1:0][DATA_W-1:0] in_reg_q;
    logic [NCHAN-1:0][DATA_W-1:0] conv_q;
    logic [NCHAN-1:0]             pd_q;
    logic [NCHAN-1:0][1:0]        term_q;

    for (genvar ch = 0; ch < NCHAN; ch++) begin : g_chan
        logic hit;
        logic ld_in;
        logic ld_conv_data;
        logic ld_conv_copy;
        logic pd_hit;

        assign hit = (chan_pick == 2'(ch));
        assign ld_in = exec_q && !pd_cmd &&
                       ((load_ctrl == LD_STORE && hit) ||
                        (load_ctrl == LD_BOTH && hit) ||
                        (load_ctrl == LD_BCAST && chan_pick == BC_STORE) ||
                        (load_ctrl == LD_BCAST && chan_pick == BC_BOTH));
        assign ld_conv_copy = exec_q && !pd_cmd &&
                              ((load_ctrl == LD_UPDATE && hit) ||
                               (load_ctrl == LD_BCAST && chan_pick == BC_UPDATE));
        assign ld_conv_data = exec_q && !pd_cmd &&
                              ((load_ctrl == LD_BOTH && hit) ||
                               (load_ctrl == LD_BCAST && chan_pick == BC_BOTH));
        // flag set covers all channels, else only the picked one
        assign pd_hit = exec_q && pd_cmd &&
                        (all_channels_flag ||
                         pd_chan_pick == 2'(ch));

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                in_reg_q[ch] <= ZERO_SCALE;
            end else if (ld_in) begin
                in_reg_q[ch] <= payload_bits;
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                conv_q[ch] <= ZERO_SCALE;
            end else if (ld_conv_data) begin
                conv_q[ch] <= payload_bits;
            end else if (ld_conv_copy) begin
                conv_q[ch] <= in_reg_q[ch];
            end
        end

        // power-down state per channel; a converter update wakes it
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pd_q[ch]   <= 1'b0;
                term_q[ch] <= TERM_RST;
            end else if (pd_hit) begin
                pd_q[ch]   <= 1'b1;
                term_q[ch] <= pd_term;
            end else if (ld_conv_data || ld_conv_copy) begin
                pd_q[ch]   <= 1'b0;
            end
        end
    end

    assign conv_value       = conv_q;
    assign power_down_state = pd_q;
    assign out_term         = term_q;

    // axi4-lite write path: address and data taken independently
    logic              aw_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic              w_held_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              do_write;
    logic              wr_ctrl;
    logic              wr_status;

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready  = ~w_held_q & ~bvalid_q;
    assign do_write      = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_ctrl       = do_write && aw_addr_q[ADDR_W-1:2] == OFS_CTRL[ADDR_W-1:2]
                           && w_strb_q[0];
    assign wr_status     = do_write && aw_addr_q[ADDR_W-1:2] == OFS_STATUS[ADDR_W-1:2]
                           && w_strb_q[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (aw_addr_q[ADDR_W-1:2] == OFS_CTRL[ADDR_W-1:2] ||
                         aw_addr_q[ADDR_W-1:2] == OFS_STATUS[ADDR_W-1:2])
                        ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_en_q <= CTRL_EN_RST;
        end else if (wr_ctrl) begin
            ctrl_en_q <= w_data_q[CTRL_EN_BIT];
        end
    end

    // sticky flags: a new event beats a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q  <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            done_q  <= exec_q |
                       (done_q & ~(wr_status & w_data_q[ST_DONE_BIT]));
            abort_q <= abort_evt_q |
                       (abort_q & ~(wr_status & w_data_q[ST_ABORT_BIT]));
        end
    end

    // axi4-lite read path
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] rd_word;
    logic        rd_hit;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (s_axi_araddr[ADDR_W-1:4] == BANK_INREG) begin
            rd_word[DATA_W-1:0] = in_reg_q[s_axi_araddr[3:2]];
        end else if (s_axi_araddr[ADDR_W-1:4] == BANK_CONV) begin
            rd_word[DATA_W-1:0] = conv_q[s_axi_araddr[3:2]];
        end else begin
            case (s_axi_araddr[ADDR_W-1:2])
                OFS_CTRL[ADDR_W-1:2]: begin
                    rd_word[CTRL_EN_BIT] = ctrl_en_q;
                end
                OFS_STATUS[ADDR_W-1:2]: begin
                    rd_word[ST_ACTIVE_BIT]         = (state_q == ST_SHIFT);
                    rd_word[ST_CNT_LSB +: CNT_W]   = cnt_q;
                    rd_word[ST_DONE_BIT]           = done_q;
                    rd_word[ST_ABORT_BIT]          = abort_q;
                end
                OFS_LAST[ADDR_W-1:2]: begin
                    rd_word[WORD_W-1:0] = word_q;
                end
                OFS_PD[ADDR_W-1:2]: begin
                    rd_word[NCHAN-1:0] = pd_q;
                    rd_word[PD_TERM_LSB +: 2*NCHAN] = term_q;
                end
                default: begin
                    rd_hit = 1'b0;
                end
            endcase
        end
    end

    assign s_axi_arready = ~rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;
endmodule : qdsc_decoder
`default_nettype wire

//--- tb/qdsc_decoder_sva.sv
// port checker for the serial command decoder
// bound from the testbench top; sees only the decoder's ports
`timescale 1ns/1ps
`default_nettype none
module qdsc_decoder_sva
    import qdsc_pkg::*;
(
    // clock and reset
    input wire logic                    aclk,
    input wire logic                    aresetn,
    // register bus
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic                    s_axi_rvalid,
    // link and results
    input wire logic                    link_frame_n,
    input wire logic [NCHAN-1:0][DATA_W-1:0] conv_value,
    input wire logic [NCHAN-1:0]        power_down_state,
    input wire logic [NCHAN-1:0][1:0]   out_term
);
    logic [3:0]                    quiet_q;
    logic [NCHAN-1:0][1:0]         term_q;
    logic [NCHAN-1:0][DATA_W-1:0]  conv_q;
    logic [NCHAN-1:0]              term_chg;
    logic [NCHAN-1:0]              conv_chg;

    // outputs settle a few cycles after the pins
    always_ff @(posedge aclk) begin
        if (!aresetn || !link_frame_n) quiet_q <= 4'h0;
        else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
    end
    always_ff @(posedge aclk) begin
        term_q <= out_term;
        conv_q <= conv_value;
    end
    always_comb begin
        for (int i = 0; i < NCHAN; i++) begin
            term_chg[i] = out_term[i] != term_q[i];
            conv_chg[i] = conv_value[i] != conv_q[i];
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    chk_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during data");
    chk_reset_zero: assert property ($rose(aresetn) |-> conv_value == '0
        && power_down_state == '0 && out_term == '0) else $error("not zero after reset");
    chk_idle_frame_quiet: assert property (quiet_q == 4'hf |-> $stable(conv_value)
        && $stable(power_down_state) && $stable(out_term)) else $error("change without frame");
    chk_term_needs_pd: assert property (|term_chg |-> (term_chg & ~power_down_state) == '0)
        else $error("termination changed without power down");
    chk_update_wakes: assert property (|conv_chg |-> (conv_chg & power_down_state) == '0)
        else $error("updated channel still powered down");
endmodule : qdsc_decoder_sva
`default_nettype wire

//--- tb/qdsc_host_model.sv
// serial host model driving frame sync, serial clock and data
// clock runs only inside frames, 125 ns period, unrelated to aclk
`timescale 1ns/1ps
`default_nettype none
module qdsc_host_model (
    // link pins
    output var logic link_sclk,
    output var logic link_din,
    output var logic link_frame_n
);
    initial {link_sclk, link_din, link_frame_n} = 3'h5;
    // n below 16 aborts; above 16 sends junk pulses
    task automatic send(input logic [15:0] w, input int n);
        link_frame_n <= 1'b0;
        #62.5;
        for (int i = 0; i < n; i++) begin
            link_din <= (i < 16) ? w[15-i] : ~link_din;
            #62.5 link_sclk <= 1'b0;
            #62.5 link_sclk <= 1'b1;
        end
        #62.5 link_frame_n <= 1'b1;
        link_din <= ~link_din;
        #300;
    endtask : send
endmodule : qdsc_host_model
`default_nettype wire

//--- tb/tb_qdsc_decoder.sv
// testbench top for the serial command decoder
// register bus driven here, link through the host model
`timescale 1ns/1ps
`default_nettype none
module tb_qdsc_decoder
    import qdsc_pkg::*;
;
    logic aclk, aresetn, link_sclk, link_din, link_frame_n;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [NCHAN-1:0][DATA_W-1:0] conv_value, exp_conv;
    logic [NCHAN-1:0] power_down_state, exp_pd;
    logic [NCHAN-1:0][1:0] out_term, exp_term;
    int fails, cmp_count, cyc;

    qdsc_decoder dut (.*);
    qdsc_host_model host (.*);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            report_and_stop;
        end
    end

    task automatic chk(input logic [63:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, b = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        while (!b) begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            {b, resp} = {s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
        logic ta, v = 1'b0;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        while (!v) begin
            @(negedge aclk);
            ta = s_axi_arvalid & s_axi_arready;
            {v, rdv, resp} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk(rdv & m, e);
        chk(resp, er);
    endtask : rd_chk
    task automatic state_chk;
        chk(conv_value, exp_conv);
        chk({out_term, power_down_state}, {exp_term, exp_pd});
        rd_chk(OFS_PD, 32'hfff, {20'h0, exp_term, exp_pd}, RESP_OKAY);
    endtask : state_chk
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, exp_conv, exp_pd, exp_term} = '0;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        state_chk;
        rd_chk(OFS_CTRL, 32'hffffffff, 32'h1, RESP_OKAY);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            host.send({LD_STORE, c[1:0], 12'ha50 + 12'(c)}, 16);
            rd_chk(8'h10 + 8'(4*c), 32'hfff, 32'ha50 + 32'(c), RESP_OKAY);
            state_chk;
            host.send({LD_UPDATE, c[1:0], 12'hfff}, 16);
            exp_conv[c] = 12'ha50 + 12'(c);
            state_chk;
            host.send({LD_BOTH, c[1:0], 12'h3c0 + 12'(c)}, 16);
            exp_conv[c] = 12'h3c0 + 12'(c);
            rd_chk(8'h10 + 8'(4*c), 32'hfff, 32'h3c0 + 32'(c), RESP_OKAY);
            state_chk;
        end
        $display("test single channel done");
        host.send({LD_BCAST, BC_STORE, 12'h7e1}, 16);
        state_chk;
        host.send({LD_BCAST, BC_UPDATE, 12'h000}, 16);
        exp_conv = {4{12'h7e1}};
        state_chk;
        host.send({LD_BCAST, BC_BOTH, 12'h0ff}, 16);
        exp_conv = {4{12'h0ff}};
        state_chk;
        for (int c = 0; c < 4; c++) rd_chk(8'h10 + 8'(4*c), 32'hfff, 32'h0ff, RESP_OKAY);
        $display("test broadcast done");
        for (int c = 0; c < 4; c++) begin
            host.send({LD_BCAST, BC_PDOWN, 1'b0, c[1:0], c[1:0], 7'h55}, 16);
            exp_pd[c] = 1'b1;
            exp_term[c] = c[1:0];
            state_chk;
        end
        host.send({LD_BCAST, BC_PDOWN, 1'b1, 2'b10, TERM_1K, 7'h2a}, 16);
        exp_pd = 4'hf;
        exp_term = {4{TERM_1K}};
        state_chk;
        host.send({LD_BOTH, 2'b01, 12'h123}, 16);
        exp_conv[1] = 12'h123;
        exp_pd[1] = 1'b0;
        state_chk;
        $display("test power down done");
        host.send({LD_STORE, 2'b00, 12'hfff}, 10);
        rd_chk(8'h10, 32'hfff, 32'h0ff, RESP_OKAY);
        rd_chk(OFS_STATUS, 32'h200, 32'h200, RESP_OKAY);
        rd_chk(OFS_LAST, 32'hffff, 32'h9123, RESP_OKAY);
        host.send({LD_STORE, 2'b10, 12'habc}, 20);
        rd_chk(OFS_LAST, 32'hffff, 32'h2abc, RESP_OKAY);
        rd_chk(8'h18, 32'hfff, 32'habc, RESP_OKAY);
        state_chk;
        $display("test framing done");
        rd_chk(8'h40, 32'hffffffff, 32'h0, RESP_SLVERR);
        wr(OFS_LAST, 32'h0);
        chk(resp, RESP_SLVERR);
        wr(OFS_STATUS, 32'h300);
        chk(resp, RESP_OKAY);
        rd_chk(OFS_STATUS, 32'h300, 32'h0, RESP_OKAY);
        wr(OFS_CTRL, 32'h0);
        chk(resp, RESP_OKAY);
        host.send({LD_BOTH, 2'b00, 12'h555}, 16);
        state_chk;
        wr(OFS_CTRL, 32'h1);
        host.send({LD_BOTH, 2'b00, 12'h555}, 16);
        exp_conv[0] = 12'h555;
        exp_pd[0] = 1'b0;
        state_chk;
        $display("test register bus done");
        report_and_stop;
    end
endmodule : tb_qdsc_decoder

bind qdsc_decoder qdsc_decoder_sva u_sva (.*);
`default_nettype wire
